// ==== shared/oob_pkg.sv ====
`default_nettype none
package oob_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int BURST_NS         = 1600;
  localparam int GAP_INIT_NS      = 4800;
  localparam int GAP_WAKE_NS      = 1600;
  localparam int DET_WAKE_MIN_NS  = 1000;
  localparam int DET_WAKE_MAX_NS  = 2400;
  localparam int DET_INIT_MIN_NS  = 3500;
  localparam int DET_INIT_MAX_NS  = 5200;

  // least times round up, longest times round down
  localparam logic [7:0] BURST_CYC    = 8'((BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] GAP_INIT_CYC = 8'((GAP_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] GAP_WAKE_CYC = 8'((GAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WAKE_MIN_CYC = 8'((DET_WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WAKE_MAX_CYC = 8'(DET_WAKE_MAX_NS / CLK_PERIOD_NS);
  localparam logic [7:0] INIT_MIN_CYC = 8'((DET_INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] INIT_MAX_CYC = 8'(DET_INIT_MAX_NS / CLK_PERIOD_NS);
  localparam logic [7:0] GAP_SAT_CYC  = 8'hff;

  // ----------------------------------------------------------------
  // sequence counts
  // ----------------------------------------------------------------
  localparam logic [2:0] OOB_ITER     = 3'h6;
  localparam logic [2:0] DET_STREAK   = 3'h4;
  localparam logic [7:0] ALIGN_PERIOD = 8'hfe;
  localparam logic [1:0] ALIGN_PAIR   = 2'h2;
  localparam int         FIFO_DEPTH   = 32;

  // ----------------------------------------------------------------
  // line words
  // ----------------------------------------------------------------
  localparam logic [31:0] BURST_DWORD = 32'h78787878;
  localparam logic [3:0]  BURST_K     = 4'h0;
  localparam logic [31:0] ALIGN_DWORD = 32'h7b4a4abc;
  localparam logic [3:0]  ALIGN_K     = 4'h1;

  typedef struct packed {
    logic [3:0]  k;
    logic [31:0] d;
  } oob_word_t;

  typedef enum logic {OOB_KIND_WAKE, OOB_KIND_INIT} oob_kind_t;
  typedef enum logic {OOB_BIST_RETIMED, OOB_BIST_FAR_ANALOG} oob_bist_t;

endpackage : oob_pkg
`default_nettype wire

// ==== rtl/oob_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module oob_fifo
  import oob_pkg::*;
#(
  parameter int W     = 36,
  parameter int DEPTH = 32
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : oob_fifo
`default_nettype wire

// ==== rtl/oob_phy_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module oob_phy_ctrl
  import oob_pkg::*;
#(
  parameter bit FAR_ANALOG_SUP  = 1'b1,
  parameter bit NEAR_ANALOG_SUP = 1'b1
)
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      nrst,
  // oob transmit request
  input  wire logic      tx_oob_valid,
  input  wire oob_kind_t tx_oob_kind,
  output logic           tx_oob_ready,
  // link layer transmit words
  input  wire logic      lnk_tx_valid,
  input  wire oob_word_t lnk_tx_word,
  output logic           lnk_tx_ready,
  // serializer
  output oob_word_t      ser_word,
  output logic           ser_valid,
  input  wire logic      ser_ready,
  output logic           ser_elec_idle,
  // receive envelope and data_recovery_circuit words
  input  wire logic      rx_squelch_active,
  input  wire logic      rx_word_valid,
  input  wire oob_word_t rx_word,
  output logic           rx_word_ready,
  // detected signals
  output logic           rx_wake_det,
  output logic           rx_init_det,
  // loopback control
  input  wire logic      bist_act_valid,
  input  wire oob_bist_t bist_act_mode,
  input  wire logic      near_loop_req,
  input  wire logic      partner_quiet,
  output logic           loop_retimed,
  output logic           loop_far_analog,
  output logic           loop_near_analog
);

  // ----------------------------------------------------------------
  // oob transmit sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_GAP, TX_BURST} oob_tx_st_t;

  oob_tx_st_t tx_st_reg;
  oob_kind_t  tx_kind_reg;
  logic [7:0] tx_cnt_reg;
  logic [2:0] tx_iter_reg;

  assign tx_oob_ready = tx_st_reg == TX_IDLE;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_st_reg   <= TX_IDLE;
      tx_kind_reg <= OOB_KIND_WAKE;
      tx_cnt_reg  <= 8'h00;
      tx_iter_reg <= 3'h0;
    end
    else
    begin
      unique case (tx_st_reg)
        TX_IDLE:
          if (tx_oob_valid)
          begin
            tx_st_reg   <= TX_GAP;
            tx_kind_reg <= tx_oob_kind;
            tx_iter_reg <= 3'h0;
            tx_cnt_reg  <= (tx_oob_kind == OOB_KIND_INIT) ? GAP_INIT_CYC : GAP_WAKE_CYC;
          end
        TX_GAP:
          if (tx_cnt_reg <= 8'h01)
          begin
            tx_st_reg  <= TX_BURST;
            tx_cnt_reg <= BURST_CYC;
          end
          else
            tx_cnt_reg <= tx_cnt_reg - 8'h01;
        TX_BURST:
          if (tx_cnt_reg > 8'h01)
            tx_cnt_reg <= tx_cnt_reg - 8'h01;
          else if (tx_iter_reg == OOB_ITER - 3'h1)
            tx_st_reg <= TX_IDLE;
          else
          begin
            tx_st_reg   <= TX_GAP;
            tx_iter_reg <= tx_iter_reg + 3'h1;
            tx_cnt_reg  <= (tx_kind_reg == OOB_KIND_INIT) ? GAP_INIT_CYC : GAP_WAKE_CYC;
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // gap detector
  // ----------------------------------------------------------------
  logic       sq_q_reg;
  logic       seen_burst_reg;
  logic [7:0] gap_cnt_reg;
  logic [2:0] streak_reg;
  oob_kind_t  streak_kind_reg;
  logic       burst_start;
  logic       gap_wake_ok;
  logic       gap_init_ok;
  logic       gap_ok;
  oob_kind_t  gap_kind;

  assign burst_start = rx_squelch_active && !sq_q_reg;
  // shall and may windows are both accepted; everything outside is shall-not
  assign gap_wake_ok = gap_cnt_reg >= WAKE_MIN_CYC && gap_cnt_reg <= WAKE_MAX_CYC;
  assign gap_init_ok = gap_cnt_reg >= INIT_MIN_CYC && gap_cnt_reg <= INIT_MAX_CYC;
  assign gap_ok      = seen_burst_reg && (gap_wake_ok || gap_init_ok);
  assign gap_kind    = gap_init_ok ? OOB_KIND_INIT : OOB_KIND_WAKE;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sq_q_reg       <= 1'b0;
      seen_burst_reg <= 1'b0;
      gap_cnt_reg    <= 8'h00;
    end
    else
    begin
      sq_q_reg <= rx_squelch_active;
      if (rx_squelch_active)
      begin
        gap_cnt_reg    <= 8'h00;
        seen_burst_reg <= 1'b1;
      end
      else if (gap_cnt_reg != GAP_SAT_CYC)
        gap_cnt_reg <= gap_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      streak_reg      <= 3'h0;
      streak_kind_reg <= OOB_KIND_WAKE;
      rx_wake_det     <= 1'b0;
      rx_init_det     <= 1'b0;
    end
    else
    begin
      rx_wake_det <= 1'b0;
      rx_init_det <= 1'b0;
      if (burst_start)
      begin
        if (!gap_ok)
          streak_reg <= 3'h0;
        else if (streak_reg != 3'h0 && gap_kind != streak_kind_reg)
        begin
          streak_reg      <= 3'h1;
          streak_kind_reg <= gap_kind;
        end
        else if (streak_reg == DET_STREAK - 3'h1)
        begin
          streak_reg  <= 3'h0;
          rx_wake_det <= gap_kind == OOB_KIND_WAKE;
          rx_init_det <= gap_kind == OOB_KIND_INIT;
        end
        else
        begin
          streak_reg      <= streak_reg + 3'h1;
          streak_kind_reg <= gap_kind;
        end
      end
      else if (!rx_squelch_active && gap_cnt_reg == GAP_SAT_CYC)
        streak_reg <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // loopback mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LB_OFF, LB_RETIMED, LB_FAR_ANALOG, LB_NEAR_ANALOG} oob_lb_st_t;

  oob_lb_st_t lb_st_reg;

  assign loop_retimed     = lb_st_reg == LB_RETIMED;
  assign loop_far_analog  = lb_st_reg == LB_FAR_ANALOG;
  assign loop_near_analog = lb_st_reg == LB_NEAR_ANALOG;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lb_st_reg <= LB_OFF;
    else
    begin
      unique case (lb_st_reg)
        LB_OFF:
          if (bist_act_valid && bist_act_mode == OOB_BIST_RETIMED)
            lb_st_reg <= LB_RETIMED;
          else if (bist_act_valid && FAR_ANALOG_SUP)
            lb_st_reg <= LB_FAR_ANALOG;
          else if (NEAR_ANALOG_SUP && near_loop_req && partner_quiet)
            lb_st_reg <= LB_NEAR_ANALOG;
        LB_RETIMED:
          if (rx_init_det)
            lb_st_reg <= LB_OFF;
        LB_FAR_ANALOG:
          if (rx_init_det)
            lb_st_reg <= LB_OFF;
        LB_NEAR_ANALOG:
          // leave at once if the partner starts talking
          if (rx_init_det || !near_loop_req || !partner_quiet)
            lb_st_reg <= LB_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // retimed loop buffer
  // ----------------------------------------------------------------
  logic      rx_is_align;
  logic      fifo_in_valid;
  logic      fifo_in_ready;
  logic      fifo_out_valid;
  logic      fifo_out_ready;
  oob_word_t fifo_out_word;

  // incoming ALIGNs are dropped; the transmit side makes its own
  assign rx_is_align   = rx_word.k == ALIGN_K && rx_word.d == ALIGN_DWORD;
  assign fifo_in_valid = loop_retimed && rx_word_valid && !rx_is_align;
  assign rx_word_ready = loop_retimed ? fifo_in_ready : 1'b1;

  // words pass untouched as dwords; the encoder picks its own disparity
  oob_fifo #(
    .W     ($bits(oob_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_loop_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_word)
  );

  // ----------------------------------------------------------------
  // serializer word select
  // ----------------------------------------------------------------
  logic       ser_load;
  logic       nxt_valid;
  oob_word_t  nxt_word;
  logic [7:0] align_cnt_reg;
  logic [1:0] align_pend_reg;
  logic       send_fifo;

  assign ser_load       = !ser_valid || ser_ready;
  assign send_fifo      = loop_retimed && tx_st_reg == TX_IDLE && align_pend_reg == 2'h0
                          && fifo_out_valid;
  assign fifo_out_ready = send_fifo && ser_load;
  assign lnk_tx_ready   = tx_st_reg == TX_IDLE && lb_st_reg == LB_OFF && ser_load;

  always_comb
  begin
    nxt_valid = 1'b0;
    nxt_word  = '{k: ALIGN_K, d: ALIGN_DWORD};
    if (tx_st_reg == TX_BURST)
    begin
      nxt_valid = 1'b1;
      nxt_word  = '{k: BURST_K, d: BURST_DWORD};
    end
    else if (tx_st_reg == TX_GAP)
      nxt_valid = 1'b0;
    else if (loop_retimed)
    begin
      nxt_valid = 1'b1;
      if (send_fifo)
        nxt_word = fifo_out_word;
    end
    else if (lb_st_reg == LB_OFF)
    begin
      nxt_valid = lnk_tx_valid;
      nxt_word  = lnk_tx_word;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      align_cnt_reg  <= 8'h00;
      align_pend_reg <= 2'h0;
    end
    else if (ser_load && loop_retimed && tx_st_reg == TX_IDLE)
    begin
      if (align_pend_reg != 2'h0)
        align_pend_reg <= align_pend_reg - 2'h1;
      else if (align_cnt_reg == ALIGN_PERIOD)
      begin
        align_cnt_reg  <= 8'h00;
        align_pend_reg <= ALIGN_PAIR;
      end
      else
        align_cnt_reg <= align_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ser_valid     <= 1'b0;
      ser_word      <= '0;
      ser_elec_idle <= 1'b1;
    end
    else
    begin
      ser_elec_idle <= tx_st_reg == TX_GAP;
      if (ser_load)
      begin
        ser_valid <= nxt_valid;
        ser_word  <= nxt_word;
      end
    end
  end

endmodule : oob_phy_ctrl
`default_nettype wire

// ==== verification/oob_phy_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module oob_phy_ctrl_chk
  import oob_pkg::*;
(
  // clock and reset
  input wire logic      clk,
  input wire logic      nrst,
  // transmit side
  input wire logic      tx_oob_valid,
  input wire logic      tx_oob_ready,
  input wire oob_word_t ser_word,
  input wire logic      ser_valid,
  input wire logic      ser_elec_idle,
  // receive side
  input wire logic      rx_squelch_active,
  input wire logic      rx_wake_det,
  input wire logic      rx_init_det,
  // loopback
  input wire logic      bist_act_valid,
  input wire oob_bist_t bist_act_mode,
  input wire logic      loop_retimed,
  input wire logic      loop_far_analog
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ----------
  // gap meter
  // ----------
  logic [2:0] sq_reg;
  logic [7:0] idle_reg;
  logic [7:0] gap_reg;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      sq_reg <= 3'h0;
    else
      sq_reg <= {sq_reg[1:0], rx_squelch_active};

  // starts saturated so the idle time before the first burst never counts
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      idle_reg <= 8'hff;
    else if (rx_squelch_active)
      idle_reg <= 8'h0;
    else if (idle_reg != 8'hff)
      idle_reg <= idle_reg + 8'h1;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      gap_reg <= 8'hff;
    else if (rx_squelch_active && !sq_reg[0])
      gap_reg <= idle_reg;

  // ----------
  // properties
  // ----------
  sequence s_take;
    tx_oob_valid && tx_oob_ready;
  endsequence
  sequence s_busy;
    !tx_oob_ready [*8];
  endsequence
  property p_tx_busy;
    s_take |=> s_busy ##[1:500] tx_oob_ready;
  endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("oob send stuck");
  property p_idle_quiet;
    ser_elec_idle |-> !ser_valid;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("word in gap");
  property p_burst_word;
    !tx_oob_ready && !ser_elec_idle && ser_valid |-> ser_word == {BURST_K, BURST_DWORD};
  endproperty
  a_burst_word: assert property (p_burst_word) else $error("bad burst word");
  property p_burst_len;
    !tx_oob_ready && $fell(ser_elec_idle) |-> !ser_elec_idle [*8];
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst short");
  property p_gap_len;
    !tx_oob_ready && $rose(ser_elec_idle) |-> ser_elec_idle [*8] ##1 ser_elec_idle [*8];
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("gap short");
  property p_det_init;
    rx_init_det |-> gap_reg >= INIT_MIN_CYC && gap_reg <= INIT_MAX_CYC;
  endproperty
  a_det_init: assert property (p_det_init) else $error("init gap");
  property p_det_wake;
    rx_wake_det |-> gap_reg >= WAKE_MIN_CYC && gap_reg <= WAKE_MAX_CYC;
  endproperty
  a_det_wake: assert property (p_det_wake) else $error("wake gap");
  property p_det_edge;
    rx_wake_det || rx_init_det |-> sq_reg[0] && (!sq_reg[1] || !sq_reg[2]);
  endproperty
  a_det_edge: assert property (p_det_edge) else $error("det off burst");
  property p_loop_entry;
    $rose(loop_retimed) || $rose(loop_far_analog) |-> $past(bist_act_valid)
      && loop_retimed == ($past(bist_act_mode) == OOB_BIST_RETIMED);
  endproperty
  a_loop_entry: assert property (p_loop_entry) else $error("loop entry");
  property p_loop_exit;
    rx_init_det |-> ##[1:2] !loop_retimed && !loop_far_analog;
  endproperty
  a_loop_exit: assert property (p_loop_exit) else $error("loop kept");
endmodule : oob_phy_ctrl_chk

bind oob_phy_ctrl oob_phy_ctrl_chk oob_phy_ctrl_chk_i (.clk, .nrst, .tx_oob_valid,
  .tx_oob_ready, .ser_word, .ser_valid, .ser_elec_idle, .rx_squelch_active, .rx_wake_det,
  .rx_init_det, .bist_act_valid, .bist_act_mode, .loop_retimed, .loop_far_analog);
`default_nettype wire

// ==== verification/oob_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module oob_partner
  import oob_pkg::*;
(
  // clock and pacing
  input  wire logic  clk,
  input  wire logic  slow,
  // envelope and recovered words
  output logic       rx_squelch_active,
  output oob_word_t  rx_word,
  output logic       rx_word_valid,
  input  wire logic  rx_word_ready,
  // serializer side
  output logic       ser_ready
);
  assign ser_ready = !slow;

  initial
  begin
    rx_squelch_active = 1'b0;
    rx_word_valid = 1'b0;
    rx_word = '0;
  end

  // envelope only: idle gap then a 16-cycle burst, pair repeated
  task automatic train(input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      repeat (gap) @(posedge clk);
      #1 rx_squelch_active = 1'b1;
      repeat (16) @(posedge clk);
      #1 rx_squelch_active = 1'b0;
    end
  endtask : train

  // released bus shows the inverse so a stale value never matches
  task automatic send(input oob_word_t w);
    int n = 0;
    @(posedge clk);
    #1 rx_word_valid = 1'b1;
    rx_word = w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rx_word_ready !== 1'b1 && n < 100);
    #1 rx_word_valid = 1'b0;
    rx_word = ~w;
  endtask : send
endmodule : oob_partner
`default_nettype wire

// ==== verification/oob_phy_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("mismatch at %0t: %h vs %h", $time, (a), (b)); \
    end \
  end
module oob_phy_ctrl_tb
  import oob_pkg::*;
;
  logic      clk = 1'b0, nrst = 1'b0, slow = 1'b0;
  logic      tx_oob_valid = 1'b0, tx_oob_ready;
  oob_kind_t tx_oob_kind = OOB_KIND_WAKE;
  logic      lnk_tx_valid = 1'b0, lnk_tx_ready;
  oob_word_t lnk_tx_word = '0, ser_word, rx_word;
  logic      ser_valid, ser_ready, ser_elec_idle;
  logic      rx_squelch_active, rx_word_valid, rx_word_ready, rx_wake_det, rx_init_det;
  logic      bist_act_valid = 1'b0, near_loop_req = 1'b0, partner_quiet = 1'b0;
  oob_bist_t bist_act_mode = OOB_BIST_RETIMED;
  logic      loop_retimed, loop_far_analog, loop_near_analog;
  int        failures = 0, checked = 0, wake_n = 0, init_n = 0, refused = 0, aligns = 0;
  oob_word_t got[$];

  oob_phy_ctrl oob_phy_ctrl_i (.clk, .nrst, .tx_oob_valid, .tx_oob_kind, .tx_oob_ready,
    .lnk_tx_valid, .lnk_tx_word, .lnk_tx_ready, .ser_word, .ser_valid, .ser_ready,
    .ser_elec_idle, .rx_squelch_active, .rx_word_valid, .rx_word, .rx_word_ready,
    .rx_wake_det, .rx_init_det, .bist_act_valid, .bist_act_mode, .near_loop_req,
    .partner_quiet, .loop_retimed, .loop_far_analog, .loop_near_analog);
  oob_partner oob_partner_i (.clk, .slow, .rx_squelch_active, .rx_word, .rx_word_valid,
    .rx_word_ready, .ser_ready);

  initial
  begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (rx_wake_det === 1'b1) wake_n++;
    if (rx_init_det === 1'b1) init_n++;
    if (rx_word_valid && rx_word_ready !== 1'b1) refused++;
    if (loop_retimed === 1'b1 && ser_valid === 1'b1 && ser_ready === 1'b1)
      if (ser_word === {ALIGN_K, ALIGN_DWORD}) aligns++;
      else got.push_back(ser_word);
  end

  task automatic summarize();
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic t_link();
    @(posedge clk);
    #1 lnk_tx_valid = 1'b1;
    lnk_tx_word = {4'h0, 32'h000000a5};
    do @(posedge clk); while (lnk_tx_ready !== 1'b1);
    #1 lnk_tx_valid = 1'b0;
    `CHK(ser_valid, 1'b1)
    `CHK(ser_word, {4'h0, 32'h000000a5})
    repeat (3) @(posedge clk);
    `CHK(ser_elec_idle, 1'b0)
  endtask : t_link

  task automatic t_tx(input oob_kind_t kind);
    int g;
    int b;
    @(posedge clk);
    #1 tx_oob_valid = 1'b1;
    tx_oob_kind = kind;
    do @(posedge clk); while (tx_oob_ready !== 1'b1);
    #1 tx_oob_valid = 1'b0;
    `CHK({tx_oob_ready, lnk_tx_ready}, 2'h0)
    for (int i = 0; i < OOB_ITER; i++)
    begin
      g = 0;
      b = 0;
      while (ser_elec_idle !== 1'b1) @(negedge clk);
      while (ser_elec_idle === 1'b1)
      begin
        g++;
        @(negedge clk);
      end
      `CHK(8'(g), kind == OOB_KIND_INIT ? GAP_INIT_CYC : GAP_WAKE_CYC)
      while (ser_elec_idle === 1'b0 && tx_oob_ready !== 1'b1)
      begin
        if (ser_valid === 1'b1) `CHK(ser_word, {BURST_K, BURST_DWORD})
        b++;
        @(negedge clk);
      end
      if (i < OOB_ITER - 1) `CHK(8'(b), BURST_CYC)
    end
    `CHK(ser_elec_idle, 1'b0)
  endtask : t_tx

  task automatic t_det(input int n, input int gap, input int w, input int in);
    int w0 = wake_n;
    int i0 = init_n;
    oob_partner_i.train(n, gap);
    repeat (300) @(posedge clk);
    `CHK(wake_n - w0, w)
    `CHK(init_n - i0, in)
  endtask : t_det

  task automatic t_loop(input oob_bist_t mode);
    @(posedge clk);
    #1 bist_act_valid = 1'b1;
    bist_act_mode = mode;
    @(posedge clk);
    #1 bist_act_valid = 1'b0;
    `CHK({loop_retimed, loop_far_analog}, mode == OOB_BIST_RETIMED ? 2'h2 : 2'h1)
    if (mode == OOB_BIST_RETIMED)
    begin
      got.delete();
      slow = 1'b1;
      fork
        for (int i = 1; i <= 40; i++)
          oob_partner_i.send(i == 7 ? {ALIGN_K, ALIGN_DWORD} : {4'h0, 32'(i)});
        begin
          repeat (120) @(posedge clk);
          #1 slow = 1'b0;
        end
      join
      repeat (40) @(posedge clk);
      `CHK(refused > 0, 1'b1)
      `CHK(aligns > 0, 1'b1)
      `CHK(got.size(), 39)
      foreach (got[j]) `CHK(got[j], {4'h0, 32'(j < 6 ? j + 1 : j + 2)})
    end
    // a wake must not end the loop, only an init does
    oob_partner_i.train(5, 16);
    repeat (20) @(posedge clk);
    `CHK({loop_retimed, loop_far_analog}, mode == OOB_BIST_RETIMED ? 2'h2 : 2'h1)
    `CHK({ser_valid, lnk_tx_ready}, {mode == OOB_BIST_RETIMED, 1'b0})
    oob_partner_i.train(5, 40);
    repeat (20) @(posedge clk);
    `CHK({loop_retimed, loop_far_analog}, 2'h0)
  endtask : t_loop

  task automatic t_near();
    @(posedge clk);
    #1 near_loop_req = 1'b1;
    partner_quiet = 1'b1;
    repeat (2) @(posedge clk);
    `CHK(loop_near_analog, 1'b1)
    #1 partner_quiet = 1'b0;
    repeat (2) @(posedge clk);
    `CHK(loop_near_analog, 1'b0)
    #1 near_loop_req = 1'b0;
  endtask : t_near

  initial
  begin
    repeat (6) @(posedge clk);
    `CHK({ser_elec_idle, ser_valid}, 2'h2)
    #1 nrst = 1'b1;
    t_link();
    t_tx(OOB_KIND_WAKE);
    t_tx(OOB_KIND_INIT);
    t_det(5, 16, 1, 0);
    t_det(5, 40, 0, 1);
    t_det(5, 30, 0, 0);
    t_det(5, 60, 0, 0);
    t_det(4, 40, 0, 0);
    t_loop(OOB_BIST_RETIMED);
    t_loop(OOB_BIST_FAR_ANALOG);
    t_near();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule : oob_phy_ctrl_tb
`default_nettype wire
